// ==== ptoc_pkg.sv ====
// package for the trigger output cascade control block
// assumes a 32-bit classic wishbone register bus and one clock
package ptoc_pkg;
	localparam int unsigned PTOC_UNITS = 4;
	localparam logic [11:0] PTOC_ADR_INDEX = 12'h520;
	localparam logic [11:0] PTOC_ADR_TGT_NS = 12'h530;
	localparam logic [11:0] PTOC_ADR_TGT_S = 12'h534;
	localparam logic [11:0] PTOC_ADR_CTL1 = 12'h538;
	localparam logic [11:0] PTOC_ADR_CTL0 = 12'h524;
	localparam logic [11:0] PTOC_ADR_STAT = 12'h528;
	localparam int unsigned PTOC_B_CHAIN = 31;
	localparam int unsigned PTOC_B_TAIL = 30;
	localparam int unsigned PTOC_B_UPSEL_HI = 27;
	localparam int unsigned PTOC_B_UPSEL_LO = 26;
	localparam int unsigned PTOC_B_NOW = 25;
	localparam int unsigned PTOC_B_NOTIFY = 24;
	localparam int unsigned PTOC_B_EDGE = 23;
	localparam int unsigned PTOC_B_ITER_HI = 15;
	localparam logic [31:0] PTOC_CTL1_WMASK = 32'hcf80ffff;
	localparam int unsigned PTOC_B_SRST = 2;
	localparam int unsigned PTOC_B_EN = 3;
	localparam int unsigned PTOC_B_ACTIVE = 4;
	localparam int unsigned PTOC_B_DONE = 0;
	localparam int unsigned PTOC_B_ERR = 1;
	localparam logic [29:0] PTOC_NS_MASK = 30'h3fffffff;
	localparam logic [31:0] PTOC_CTL1_RST = 32'h00000000;

	typedef enum logic [1:0] {
		PTOC_IDLE = 2'b00,
		PTOC_ARMED = 2'b01,
		PTOC_FIRE = 2'b11
	} ptoc_state_t;

	typedef struct packed {
		logic chain;
		logic tail;
		logic [1:0] upsel;
		logic now;
		logic notify;
		logic edge_neg;
		logic [15:0] iter;
	} ptoc_cfg_t;

	function automatic ptoc_cfg_t ptoc_unpack(input logic [31:0] w);
		ptoc_cfg_t c;
		c.chain = w[PTOC_B_CHAIN];
		c.tail = w[PTOC_B_TAIL];
		c.upsel = w[PTOC_B_UPSEL_HI:PTOC_B_UPSEL_LO];
		c.now = w[PTOC_B_NOW];
		c.notify = w[PTOC_B_NOTIFY];
		c.edge_neg = w[PTOC_B_EDGE];
		c.iter = w[PTOC_B_ITER_HI:0];
		return c;
	endfunction
endpackage

// ==== ptoc_unit.sv ====
// one trigger output unit: waits for target or upstream done, fires, counts passes
// assumes time inputs are synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module ptoc_unit
	import ptoc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	input wire logic enable_set_i,
	input wire ptoc_cfg_t cfg_i,
	input wire logic ring_has_tail_i,
	input wire logic [61:0] target_i,
	input wire logic [61:0] now_i,
	input wire logic up_done_i,
	output logic enable_o,
	output logic active_o,
	output logic done_o,
	output logic fault_o,
	output logic fire_o,
	output logic pass_on_o
);
	ptoc_state_t state_reg, state_next;
	logic [15:0] pass_reg;
	logic past_w, reached_w, start_w, last_pass_w;

	assign reached_w = (now_i >= target_i);
	assign past_w = (now_i > target_i);
	// a late target without immediate fire still fires, and also raises a fault when notify is set
	// software starts any unit; a chain member, the head included, also starts on its upstream unit
	assign start_w = enable_o || (cfg_i.chain && up_done_i);
	// only tail counts; chain with no tail repeats forever
	assign last_pass_w = !cfg_i.chain || !cfg_i.tail || (pass_reg == cfg_i.iter);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			PTOC_IDLE: if (start_w) state_next = PTOC_ARMED;
			PTOC_ARMED:
				if (cfg_i.chain || (cfg_i.now && past_w) || reached_w)
					state_next = PTOC_FIRE;
			PTOC_FIRE: state_next = PTOC_IDLE;
			default: state_next = PTOC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || soft_rst_i)
		begin
			state_reg <= PTOC_IDLE;
			pass_reg <= 16'h0000;
			enable_o <= 1'b0;
			done_o <= 1'b0;
			fault_o <= 1'b0;
			fire_o <= 1'b0;
			pass_on_o <= 1'b0;
			active_o <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			active_o <= (state_next != PTOC_IDLE);
			fire_o <= (state_next == PTOC_FIRE);
			// the tail keeps its last pass to itself, which ends the chain
			pass_on_o <= (state_next == PTOC_FIRE) && !(cfg_i.chain && cfg_i.tail && last_pass_w);
			if (state_reg == PTOC_FIRE)
				enable_o <= 1'b0;
			else if (enable_set_i)
				enable_o <= 1'b1;
			if (state_reg == PTOC_FIRE)
			begin
				done_o <= cfg_i.notify && last_pass_w;
				if (cfg_i.chain && cfg_i.tail && ring_has_tail_i)
					pass_reg <= last_pass_w ? 16'h0000 : pass_reg + 16'h0001;
			end
			else
				done_o <= 1'b0;
			if (state_reg == PTOC_ARMED && !cfg_i.chain && past_w && !cfg_i.now)
				fault_o <= cfg_i.notify;
			else
				fault_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== ptoc_top.sv ====
// trigger output cascade control: four units behind an indexed wishbone register window
// assumes a classic wishbone master on clk_i and a synchronous system time input
// How it works
// - chain enable bit makes unit a cascade member
// - tail bit marks last unit of chain
// - no tail anywhere: loop forever, ignore count
// - two-bit field picks upstream done unit
// - immediate-fire bit fires on late target
// - notify bit gates done and fault reporting
// - edge bit picks negative or positive output edge
// - soft reset returns unit to idle defaults
// - index register steers per-unit register accesses
// - tail iteration count means value plus one
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ptoc_top
	import ptoc_pkg::*;
#(
	parameter int unsigned UNITS = PTOC_UNITS
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [61:0] sys_time_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic [UNITS-1:0] trig_o
);
	logic [1:0] index_reg;
	logic [31:0] ctl1_reg [UNITS];
	logic [29:0] tns_reg [UNITS];
	logic [31:0] ts_reg [UNITS];
	logic [UNITS-1:0] enable_w, active_w, done_w, fault_w, fire_w, pass_on_w;
	logic [UNITS-1:0] trig_pos_reg, trig_neg_reg;
	logic [UNITS-1:0] done_flag_reg, fault_flag_reg, srst_w, en_set_w;
	logic [UNITS-1:0] tail_w, chain_w;
	logic ring_has_tail_w;
	logic req_w, wr_w, hit_idx_w, hit_ns_w, hit_s_w, hit_c1_w, hit_c0_w, hit_st_w;
	logic [31:0] wmask_w, rd_w;

	assign req_w = cyc_i && stb_i && !ack_o;
	assign wr_w = req_w && we_i;
	assign wmask_w = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign hit_idx_w = (adr_i == PTOC_ADR_INDEX);
	assign hit_ns_w = (adr_i == PTOC_ADR_TGT_NS);
	assign hit_s_w = (adr_i == PTOC_ADR_TGT_S);
	assign hit_c1_w = (adr_i == PTOC_ADR_CTL1);
	assign hit_c0_w = (adr_i == PTOC_ADR_CTL0);
	assign hit_st_w = (adr_i == PTOC_ADR_STAT);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		return (old & ~m) | (nw & m);
	endfunction

	// unmapped addresses read zero and still ack
	always_comb
	begin
		rd_w = 32'h00000000;
		if (hit_idx_w)
			rd_w = {30'h0, index_reg};
		else if (hit_ns_w)
			rd_w = {2'b00, tns_reg[index_reg]};
		else if (hit_s_w)
			rd_w = ts_reg[index_reg];
		else if (hit_c1_w)
			rd_w = ctl1_reg[index_reg];
		else if (hit_c0_w)
			rd_w = {27'h0, active_w[index_reg], enable_w[index_reg], 3'b000};
		else if (hit_st_w)
			rd_w = {30'h0, fault_flag_reg[index_reg], done_flag_reg[index_reg]};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			index_reg <= 2'b00;
		end
		else
		begin
			ack_o <= req_w;
			dat_o <= req_w ? rd_w : 32'h00000000;
			if (wr_w && hit_idx_w && sel_i[0])
				index_reg <= dat_i[1:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < UNITS; g++)
		begin : gen_unit
			logic sel_me_w;
			ptoc_cfg_t cfg_w;
			logic up_done_w;
			logic [31:0] ns_merge_w;
			assign sel_me_w = (index_reg == 2'(g));
			assign srst_w[g] = wr_w && hit_c0_w && sel_me_w && sel_i[0] && dat_i[PTOC_B_SRST];
			assign en_set_w[g] = wr_w && hit_c0_w && sel_me_w && sel_i[0] && dat_i[PTOC_B_EN];
			assign cfg_w = ptoc_unpack(ctl1_reg[g]);
			assign ns_merge_w = merge({2'b00, tns_reg[g]}, dat_i, wmask_w);
			assign tail_w[g] = cfg_w.chain && cfg_w.tail;
			assign chain_w[g] = cfg_w.chain;
			assign up_done_w = pass_on_w[cfg_w.upsel] && (cfg_w.upsel != 2'(g));

			always_ff @(posedge clk_i)
			begin
				if (rst_i || srst_w[g])
				begin
					ctl1_reg[g] <= PTOC_CTL1_RST;
					tns_reg[g] <= 30'h00000000;
					ts_reg[g] <= 32'h00000000;
					done_flag_reg[g] <= 1'b0;
					fault_flag_reg[g] <= 1'b0;
				end
				else
				begin
					if (wr_w && sel_me_w && hit_c1_w)
						ctl1_reg[g] <= merge(ctl1_reg[g], dat_i, wmask_w & PTOC_CTL1_WMASK);
					if (wr_w && sel_me_w && hit_ns_w)
						tns_reg[g] <= ns_merge_w[29:0] & PTOC_NS_MASK;
					if (wr_w && sel_me_w && hit_s_w)
						ts_reg[g] <= merge(ts_reg[g], dat_i, wmask_w);
					// write one clears; a new event in the same cycle wins
					if (done_w[g])
						done_flag_reg[g] <= 1'b1;
					else if (wr_w && sel_me_w && hit_st_w && sel_i[0] && dat_i[PTOC_B_DONE])
						done_flag_reg[g] <= 1'b0;
					if (fault_w[g])
						fault_flag_reg[g] <= 1'b1;
					else if (wr_w && sel_me_w && hit_st_w && sel_i[0] && dat_i[PTOC_B_ERR])
						fault_flag_reg[g] <= 1'b0;
				end
			end

			ptoc_unit u_unit (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.soft_rst_i(srst_w[g]),
				.enable_set_i(en_set_w[g]),
				.cfg_i(cfg_w),
				.ring_has_tail_i(ring_has_tail_w),
				.target_i({ts_reg[g], tns_reg[g]}),
				.now_i(sys_time_i),
				.up_done_i(up_done_w),
				.enable_o(enable_w[g]),
				.active_o(active_w[g]),
				.done_o(done_w[g]),
				.fault_o(fault_w[g]),
				.fire_o(fire_w[g]),
				.pass_on_o(pass_on_w[g])
			);

			// output toggles per fire; the edge bit picks which clock edge launches it
			always_ff @(posedge clk_i)
			begin
				if (rst_i || srst_w[g])
					trig_pos_reg[g] <= 1'b0;
				else if (!cfg_w.edge_neg && fire_w[g])
					trig_pos_reg[g] <= ~trig_pos_reg[g];
			end

			always_ff @(negedge clk_i)
			begin
				if (rst_i || srst_w[g])
					trig_neg_reg[g] <= 1'b0;
				else if (cfg_w.edge_neg && fire_w[g])
					trig_neg_reg[g] <= ~trig_neg_reg[g];
			end
		end
	endgenerate

	// pin is the xor of one toggle flop per edge, so either edge can move it
	assign trig_o = trig_pos_reg ^ trig_neg_reg;
	assign ring_has_tail_w = |tail_w;
endmodule
`default_nettype wire

// ==== ptoc_time_src.sv ====
// partner model: free-running system time source for the trigger units
// assumes one clock; time advances one tick per cycle from zero after reset
`timescale 1ns/1ps
`default_nettype none
module ptoc_time_src
(
	input wire logic clk_i,
	input wire logic rst_i,
	output logic [61:0] time_o
);
	// counting from zero makes every zero target late within a few cycles
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			time_o <= 62'h0;
		else
			time_o <= time_o + 62'h1;
	end
endmodule
`default_nettype wire

// ==== ptoc_top_properties.sv ====
// checker for the trigger output cascade control top ports
// assumes the classic wishbone timing of the hand-over contract
`timescale 1ns/1ps
`default_nettype none
module ptoc_top_properties
	import ptoc_pkg::*;
#(
	parameter int unsigned UNITS = PTOC_UNITS
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [61:0] sys_time_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [UNITS-1:0] trig_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic rd_ack = ack_o && !we_i;
	wire logic mapped = adr_i == PTOC_ADR_INDEX || adr_i == PTOC_ADR_CTL0
		|| adr_i == PTOC_ADR_STAT || adr_i == PTOC_ADR_TGT_NS
		|| adr_i == PTOC_ADR_TGT_S || adr_i == PTOC_ADR_CTL1;
	chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	chk_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	chk_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	chk_ctl1_resv: assert property (rd_ack && adr_i == PTOC_ADR_CTL1
		|-> (dat_o & ~PTOC_CTL1_WMASK) == 32'h0)
		else $error("reserved control bits read nonzero");
	chk_idx_width: assert property (rd_ack && adr_i == PTOC_ADR_INDEX |-> dat_o[31:2] == 30'h0)
		else $error("index pointer wider than two bits");
	chk_stat_width: assert property (rd_ack && adr_i == PTOC_ADR_STAT |-> dat_o[31:2] == 30'h0)
		else $error("status upper bits nonzero");
	chk_ns_resv: assert property (rd_ack && adr_i == PTOC_ADR_TGT_NS |-> dat_o[31:30] == 2'h0)
		else $error("target ns upper bits nonzero");
	chk_unmapped_zero: assert property (rd_ack && !mapped |-> dat_o == 32'h0)
		else $error("unmapped read nonzero");
	chk_trig_reset: assert property ($past(rst_i) |-> trig_o == '0)
		else $error("trigger output not idle after reset");
	cover property (ack_o && we_i && adr_i == PTOC_ADR_CTL0);
	cover property (rd_ack && adr_i == PTOC_ADR_CTL1);
	cover property ($changed(trig_o));
endmodule
bind ptoc_top ptoc_top_properties #(.UNITS(UNITS)) ptoc_top_properties_i (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .sys_time_i(sys_time_i), .dat_o(dat_o), .ack_o(ack_o), .trig_o(trig_o));
`default_nettype wire

// ==== ptoc_top_test.sv ====
// testbench for the trigger output cascade control block
// assumes one 10 MHz clock and the partner time source
`timescale 1ns/1ps
`default_nettype none
module ptoc_top_test;
	import ptoc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req = 1'b0;
	logic we = 1'b0;
	logic [11:0] adr = 12'h0;
	logic [31:0] dat = 32'h0;
	logic [61:0] sys_time;
	logic [31:0] dat_o;
	logic ack_o;
	logic [3:0] trig_o;
	logic [3:0] trig_snap;
	int fail_count = 0;
	int n_tests = 0;
	ptoc_time_src ptoc_time_src_i (.clk_i(clk_i), .rst_i(rst_i), .time_o(sys_time));
	ptoc_top ptoc_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req), .we_i(we),
		.adr_i(adr), .sel_i(4'hf), .dat_i(dat), .sys_time_i(sys_time), .dat_o(dat_o),
		.ack_o(ack_o), .trig_o(trig_o));
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{req, we, adr, dat} <= {1'b1, w, a, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		req <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg_%h", a), e, dat_o);
	endtask
	// a unit firing shows as a toggle of its output; give it a bounded span
	task automatic wait_tog(input int u);
		logic was;
		int k;
		was = trig_o[u];
		k = 0;
		while (trig_o[u] === was && k < 60)
		begin
			@(posedge clk_i);
			k++;
		end
		chk($sformatf("trig_%0d", u), 32'h1, {31'h0, trig_o[u] !== was});
	endtask
	// a posedge launch is first seen at a falling edge, a negedge launch at a rising one
	task automatic wait_edge(input int u, input logic neg);
		logic was;
		logic at_pos;
		int k;
		was = trig_o[u];
		at_pos = 1'b0;
		k = 0;
		while (trig_o[u] === was && k < 120)
		begin
			if (k[0])
				@(posedge clk_i);
			else
				@(negedge clk_i);
			at_pos = k[0];
			k++;
		end
		chk($sformatf("edge_%0d", u), {30'h0, 1'b1, neg}, {30'h0, trig_o[u] !== was, at_pos});
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(PTOC_ADR_CTL1, PTOC_CTL1_RST);
		bus(1'b1, PTOC_ADR_INDEX, 32'h1);
		bus(1'b1, PTOC_ADR_CTL1, 32'hffffffff);
		bus(1'b1, PTOC_ADR_INDEX, 32'h2);
		rd(PTOC_ADR_CTL1, 32'h0);
		bus(1'b1, PTOC_ADR_INDEX, 32'h1);
		rd(PTOC_ADR_CTL1, PTOC_CTL1_WMASK);
		bus(1'b1, PTOC_ADR_CTL0, 32'h4);
		rd(PTOC_ADR_CTL1, 32'h0);
		rd(12'h5f0, 32'h0);
		$display("test registers done");
		bus(1'b1, PTOC_ADR_INDEX, 32'h0);
		bus(1'b1, PTOC_ADR_CTL1, 32'h03000000);
		bus(1'b1, PTOC_ADR_CTL0, 32'h8);
		wait_tog(0);
		rd(PTOC_ADR_STAT, 32'h1);
		rd(PTOC_ADR_CTL0, 32'h0);
		bus(1'b1, PTOC_ADR_STAT, 32'h3);
		bus(1'b1, PTOC_ADR_CTL1, 32'h02000000);
		bus(1'b1, PTOC_ADR_CTL0, 32'h8);
		wait_tog(0);
		rd(PTOC_ADR_STAT, 32'h0);
		bus(1'b1, PTOC_ADR_CTL0, 32'h8);
		wait_edge(0, 1'b0);
		bus(1'b1, PTOC_ADR_CTL1, 32'h02800000);
		bus(1'b1, PTOC_ADR_CTL0, 32'h8);
		wait_edge(0, 1'b1);
		$display("test fire done");
		// two-unit ring with no tail: must keep cycling until soft reset
		bus(1'b1, PTOC_ADR_CTL1, 32'h86000000);
		bus(1'b1, PTOC_ADR_INDEX, 32'h1);
		bus(1'b1, PTOC_ADR_CTL1, 32'h80000000);
		bus(1'b1, PTOC_ADR_INDEX, 32'h0);
		bus(1'b1, PTOC_ADR_CTL0, 32'h8);
		wait_tog(1);
		wait_tog(0);
		wait_tog(1);
		bus(1'b1, PTOC_ADR_CTL0, 32'h4);
		bus(1'b1, PTOC_ADR_INDEX, 32'h1);
		bus(1'b1, PTOC_ADR_CTL0, 32'h4);
		trig_snap = trig_o;
		repeat (30) @(posedge clk_i);
		chk("trig_stop", {28'h0, trig_snap}, {28'h0, trig_o});
		$display("test cascade done");
		// two-unit ring, unit 1 is tail with count 1: two passes, then it stops
		bus(1'b1, PTOC_ADR_CTL1, 32'hc1000001);
		bus(1'b1, PTOC_ADR_INDEX, 32'h0);
		bus(1'b1, PTOC_ADR_CTL1, 32'h84000000);
		bus(1'b1, PTOC_ADR_CTL0, 32'h8);
		wait_tog(1);
		wait_tog(1);
		bus(1'b1, PTOC_ADR_INDEX, 32'h1);
		rd(PTOC_ADR_STAT, 32'h1);
		trig_snap = trig_o;
		repeat (30) @(posedge clk_i);
		chk("tail_stop", {28'h0, trig_snap}, {28'h0, trig_o});
		$display("test tail done");
		close_out();
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire
